// [rtl/prx_pkg.sv]
// constants shared by the receive port, strap capture and led logic
package prx_pkg;

   // system clock and derived timing
   localparam int CLK_HZ = 50_000_000;
   localparam int BLINK_MS = 40;
   localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
   localparam int STRAP_WAIT_CYC = 4;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

   // control register fields and reset value
   localparam int CTRL_LED_EN = 0;
   localparam int CTRL_RX_EN = 1;
   localparam int CTRL_W = 2;
   localparam logic [1:0] CTRL_RESET = 2'h3;

   // status register fields
   localparam int STAT_MODE = 0;
   localparam int STAT_WAKE_SEL = 2;
   localparam int STAT_ADDR = 3;
   localparam int STAT_LINK = 5;
   localparam int STAT_FAST = 6;
   localparam int STAT_DONE = 7;

   // interrupt status and mask fields
   localparam int IRQ_FRAME = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_COL = 2;
   localparam int IRQ_LINK = 3;
   localparam int IRQ_W = 4;
   localparam logic [3:0] IRQ_RESET = 4'h0;

   // media mode codes, data-valid strap then tx-clock strap
   localparam logic [1:0] MODE_MII = 2'h0;
   localparam logic [1:0] MODE_REV_MII = 2'h1;
   localparam logic [1:0] MODE_RMII_CLK_OUT = 2'h2;
   localparam logic [1:0] MODE_RMII_CLK_IN = 2'h3;

   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {ST_CAPTURE, ST_RUN} prx_strap_t;

endpackage

// [rtl/prx_sync.sv]
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
`default_nettype none
module prx_sync #(
   parameter int W = 1
) (
   input wire logic i_clock,         // system clock
   input wire logic i_rst,           // async reset, active high
   input wire logic [W-1:0] i_async, // levels from another domain
   output logic [W-1:0] o_sync       // levels in the clock domain
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule
`default_nettype wire

// [rtl/prx_led.sv]
// link led: steady while the link is up, dark blinks repeating while activity lasts
`timescale 1ns/1ps
`default_nettype none
module prx_led #(
   parameter int BLINK_CYCLES = 2_000_000
) (
   input wire logic i_clock,    // system clock
   input wire logic i_rst,      // async reset, active high
   input wire logic i_link,     // link up at this led's speed
   input wire logic i_activity, // traffic seen
   output logic o_led           // led drive, high is lit
);
   localparam int CW = $clog2(BLINK_CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(BLINK_CYCLES - 1);
   localparam logic [CW-1:0] HALF = CW'(BLINK_CYCLES / 2);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic led_q;
   logic led_d;

   // a blink runs to the end, so steady traffic gives a steady flash rate
   always_comb begin
      cnt_d = cnt_q;
      if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end else if (i_link && i_activity) begin
         cnt_d = LOAD;
      end
      led_d = i_link && (cnt_d < HALF);
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= '0;
         led_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         led_q <= led_d;
      end
   end

   assign o_led = led_q;
endmodule
`default_nettype wire

// [rtl/prx_top.sv]
// mac-facing receive port, strap capture, leds and register slave
`timescale 1ns/1ps
`default_nettype none
module prx_top
   import prx_pkg::*;
#(
   parameter int BLINK_CYCLES = BLINK_CYC
) (
   input wire logic i_clock,             // system clock, 50 mhz
   input wire logic i_rst,               // async reset, active high
   // recovered line side, asynchronous
   input wire logic i_line_clock,        // recovered receive clock
   input wire logic [3:0] i_line_nibble, // decoded nibble
   input wire logic i_line_dv,           // nibble belongs to a frame
   input wire logic i_line_err,          // error symbol decoded
   input wire logic i_line_carrier,      // receive medium not idle
   // phy core status, same clock
   input wire logic i_tx_active,         // transmit medium busy
   input wire logic i_full_duplex,       // link is full duplex
   input wire logic i_link_up,           // link established
   input wire logic i_link_fast,         // link at 100 mbit
   input wire logic i_activity,          // traffic seen
   input wire logic i_wake_event,        // wake request level
   // strap sensing of shared pins
   input wire logic i_rx_dv_pin,         // data-valid pin level
   input wire logic i_rx_d1_pin,         // data bit 1 pin level
   input wire logic i_rx_d3_pin,         // data bit 3 pin level
   input wire logic i_led_slow_pin,      // slow led pin level
   input wire logic i_led_fast_pin,      // fast led pin level
   // mac pins
   output logic o_rx_clock,              // receive clock to mac
   output logic [3:0] o_rx_data,         // receive nibble
   output logic [3:0] o_rx_data_oe,      // per-bit output enable
   output logic o_rx_dv,                 // data valid
   output logic o_rx_dv_oe,              // data valid enable
   output logic o_rx_er,                 // receive error
   output logic o_crs,                   // carrier sense or crs_dv
   output logic o_col,                   // collision
   output logic o_link_led_slow,         // slow led or wake pin level
   output logic o_link_led_slow_oe,      // slow led pin enable
   output logic o_link_led_fast,         // fast led pin level
   output logic o_link_led_fast_oe,      // fast led pin enable
   output logic o_rmii_clock_output_mode, // tx clock pin drives 50 mhz
   output logic o_irq,                   // interrupt, active high level
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,  // write address
   input wire logic s_axi_awvalid,       // write address valid
   output logic s_axi_awready,           // write address ready
   input wire logic [31:0] s_axi_wdata,  // write data
   input wire logic [3:0] s_axi_wstrb,   // write strobes
   input wire logic s_axi_wvalid,        // write data valid
   output logic s_axi_wready,            // write data ready
   output logic [1:0] s_axi_bresp,       // write response
   output logic s_axi_bvalid,            // write response valid
   input wire logic s_axi_bready,        // write response ready
   input wire logic [7:0] s_axi_araddr,  // read address
   input wire logic s_axi_arvalid,       // read address valid
   output logic s_axi_arready,           // read address ready
   output logic [31:0] s_axi_rdata,      // read data
   output logic [1:0] s_axi_rresp,       // read response
   output logic s_axi_rvalid,            // read data valid
   input wire logic s_axi_rready         // read data ready
);
   ////////////////////////////////////////////////////////////////////////
   // synchronisers
   logic [7:0] line_s;
   logic [4:0] strap_s;
   logic led_slow_w;
   logic led_fast_w;

   prx_sync #(.W(8)) u_line_sync (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async({i_line_clock, i_line_dv, i_line_err, i_line_carrier,
                i_line_nibble}),
      .o_sync(line_s)
   );

   prx_sync #(.W(5)) u_strap_sync (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async({i_rx_dv_pin, i_rx_d3_pin, i_rx_d1_pin, i_led_fast_pin,
                i_led_slow_pin}),
      .o_sync(strap_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // strap capture
   prx_strap_t st_q, st_d;
   logic [2:0] wait_q, wait_d;
   logic [1:0] mode_q, mode_d;
   logic wake_sel_q, wake_sel_d;
   logic [1:0] addr_q, addr_d;
   logic run;
   logic is_rmii;

   // wait until the pulls have passed the synchroniser, then latch once
   always_comb begin
      st_d = st_q;
      wait_d = wait_q;
      mode_d = mode_q;
      wake_sel_d = wake_sel_q;
      addr_d = addr_q;
      unique case (st_q)
         ST_CAPTURE: begin
            wait_d = wait_q + 3'h1;
            if (wait_q == 3'(STRAP_WAIT_CYC - 1)) begin
               mode_d = strap_s[4:3];
               wake_sel_d = strap_s[2];
               addr_d = strap_s[1:0];
               st_d = ST_RUN;
            end
         end
         ST_RUN: begin
            st_d = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_q <= ST_CAPTURE;
         wait_q <= 3'h0;
         mode_q <= MODE_MII;
         wake_sel_q <= 1'b0;
         addr_q <= 2'h0;
      end else begin
         st_q <= st_d;
         wait_q <= wait_d;
         mode_q <= mode_d;
         wake_sel_q <= wake_sel_d;
         addr_q <= addr_d;
      end
   end

   assign run = (st_d == ST_RUN);
   assign is_rmii = mode_d[1];

   ////////////////////////////////////////////////////////////////////////
   // register file and axi4-lite slave
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [IRQ_W-1:0] sts_q, sts_d, mask_q, mask_d, ev;
   logic aw_got_q, aw_got_d, w_got_q, w_got_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic wstrb0_q, wstrb0_d;
   logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
   logic [1:0] bresp_d, rresp_d;
   logic [31:0] rdata_d;
   logic irq_d;

   // writes wait for both address and data; one answer at a time
   always_comb begin
      aw_got_d = aw_got_q;
      w_got_d = w_got_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb0_d = wstrb0_q;
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      sts_d = sts_q | ev;
      bvalid_d = s_axi_bvalid;
      bresp_d = s_axi_bresp;
      rvalid_d = s_axi_rvalid;
      rresp_d = s_axi_rresp;
      rdata_d = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_got_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_got_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb0_d = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid) begin
         aw_got_d = 1'b0;
         w_got_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = RESP_OKAY;
         unique case (awaddr_q)
            ADDR_CTRL: if (wstrb0_q) ctrl_d = wdata_q[CTRL_W-1:0];
            ADDR_STATUS: ;
            // a new event in the clearing cycle survives the clear
            ADDR_IRQ_STS: if (wstrb0_q) begin
               sts_d = (sts_q & ~wdata_q[IRQ_W-1:0]) | ev;
            end
            ADDR_IRQ_MASK: if (wstrb0_q) mask_d = wdata_q[IRQ_W-1:0];
            default: bresp_d = RESP_SLVERR;
         endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         rdata_d = 32'h0;
         unique case (s_axi_araddr)
            ADDR_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
            ADDR_STATUS: begin
               rdata_d[STAT_MODE +: 2] = mode_q;
               rdata_d[STAT_WAKE_SEL] = wake_sel_q;
               rdata_d[STAT_ADDR +: 2] = addr_q;
               rdata_d[STAT_LINK] = i_link_up;
               rdata_d[STAT_FAST] = i_link_fast;
               rdata_d[STAT_DONE] = (st_q == ST_RUN);
            end
            ADDR_IRQ_STS: rdata_d[IRQ_W-1:0] = sts_q;
            ADDR_IRQ_MASK: rdata_d[IRQ_W-1:0] = mask_q;
            default: rresp_d = RESP_SLVERR;
         endcase
      end
      awready_d = !aw_got_d && !bvalid_d;
      wready_d = !w_got_d && !bvalid_d;
      arready_d = !rvalid_d;
      irq_d = |(sts_d & mask_d);
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb0_q <= 1'b0;
         ctrl_q <= CTRL_RESET;
         sts_q <= IRQ_RESET;
         mask_q <= IRQ_RESET;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= 32'h0;
         o_irq <= 1'b0;
      end else begin
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb0_q <= wstrb0_d;
         ctrl_q <= ctrl_d;
         sts_q <= sts_d;
         mask_q <= mask_d;
         s_axi_awready <= awready_d;
         s_axi_wready <= wready_d;
         s_axi_bvalid <= bvalid_d;
         s_axi_bresp <= bresp_d;
         s_axi_arready <= arready_d;
         s_axi_rvalid <= rvalid_d;
         s_axi_rresp <= rresp_d;
         s_axi_rdata <= rdata_d;
         o_irq <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive port and pin drivers
   logic clk_prev_q, clk_prev_d, link_prev_q;
   logic [3:0] nib_q, nib_d;
   logic dv_q, dv_d, er_q, er_d, col_q, col_d;
   logic rise, led_en, slow_d, fast_d;

   // the line clock is sampled, so nibble, data valid and error move on the same
   // system edge as the clock copy; skew is one system period at most
   assign rise = line_s[7] && !clk_prev_q;
   assign led_en = ctrl_q[CTRL_LED_EN];

   always_comb begin
      clk_prev_d = line_s[7];
      nib_d = nib_q;
      dv_d = dv_q;
      er_d = er_q;
      if (rise) begin
         nib_d = line_s[3:0];
         dv_d = line_s[6] && ctrl_q[CTRL_RX_EN];
         er_d = line_s[6] && line_s[5] && ctrl_q[CTRL_RX_EN];
      end
      col_d = !is_rmii && !i_full_duplex && i_tx_active
              && line_s[4];
      ev = '0;
      ev[IRQ_FRAME] = dv_q && !dv_d;
      ev[IRQ_ERR] = er_d && !er_q;
      ev[IRQ_COL] = col_d && !col_q;
      ev[IRQ_LINK] = i_link_up != link_prev_q;
      // slow led pin: led or open-drain wake, chosen from the capture edge on
      slow_d = wake_sel_d ? 1'b0 : (led_slow_w && led_en);
      fast_d = led_fast_w && led_en;
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         clk_prev_q <= 1'b0;
         link_prev_q <= 1'b0;
         nib_q <= 4'h0;
         dv_q <= 1'b0;
         er_q <= 1'b0;
         col_q <= 1'b0;
         o_rx_clock <= 1'b0;
         o_rx_data <= 4'h0;
         o_rx_data_oe <= 4'h0;
         o_rx_dv <= 1'b0;
         o_rx_dv_oe <= 1'b0;
         o_rx_er <= 1'b0;
         o_crs <= 1'b0;
         o_col <= 1'b0;
         o_link_led_slow <= 1'b0;
         o_link_led_slow_oe <= 1'b0;
         o_link_led_fast <= 1'b0;
         o_link_led_fast_oe <= 1'b0;
         o_rmii_clock_output_mode <= 1'b0;
      end else begin
         clk_prev_q <= clk_prev_d;
         link_prev_q <= i_link_up;
         nib_q <= nib_d;
         dv_q <= dv_d;
         er_q <= er_d;
         col_q <= col_d;
         o_rx_clock <= !is_rmii && line_s[7];
         o_rx_data <= {nib_d[3], nib_d[2] && !is_rmii, nib_d[1:0]};
         o_rx_data_oe <= {run, run && (is_rmii ? irq_d : 1'b1),
                          run, run};
         o_rx_dv <= dv_d;
         o_rx_dv_oe <= run;
         o_rx_er <= er_d;
         o_crs <= is_rmii ? (line_s[4] || dv_d)
                          : line_s[4];
         o_col <= col_d;
         o_link_led_slow <= slow_d;
         o_link_led_slow_oe <= run && (!wake_sel_d || i_wake_event);
         o_link_led_fast <= fast_d;
         o_link_led_fast_oe <= run;
         o_rmii_clock_output_mode <= (mode_d == MODE_RMII_CLK_OUT);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // led blink timers, one per speed
   prx_led #(.BLINK_CYCLES(BLINK_CYCLES)) u_led_slow (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_link(i_link_up && !i_link_fast),
      .i_activity(i_activity),
      .o_led(led_slow_w)
   );

   prx_led #(.BLINK_CYCLES(BLINK_CYCLES)) u_led_fast (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_link(i_link_up && i_link_fast),
      .i_activity(i_activity),
      .o_led(led_fast_w)
   );
endmodule
`default_nettype wire

// [tb/prx_properties.sv]
// checker: timing relations at the receive port and strap pins
`timescale 1ns/1ps
`default_nettype none
module prx_properties (
   input wire logic i_clock, // system clock
   input wire logic i_rst, // async reset
   input wire logic i_tx_active, // transmit busy
   input wire logic i_full_duplex, // duplex level
   input wire logic i_rx_dv_pin, // mode strap, high is rmii
   input wire logic i_rx_d1_pin, // wake strap
   input wire logic i_rx_d3_pin, // tx clock strap
   input wire logic o_rx_clock, // receive clock
   input wire logic [3:0] o_rx_data, // receive nibble
   input wire logic [3:0] o_rx_data_oe, // nibble enables
   input wire logic o_rx_dv, // data valid
   input wire logic o_rx_dv_oe, // data valid enable
   input wire logic o_rx_er, // receive error
   input wire logic o_col, // collision
   input wire logic o_link_led_slow, // slow led or wake
   input wire logic o_rmii_clock_output_mode // tx clock drives out
);
   // straps stay put within one reset epoch, so pins stand for the mode
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);

   ////////////////////////////////////////////////////////////////////////
   col_half_dup_a: assert property (o_col |->
      $past(i_tx_active && !i_full_duplex))
      else $error("collision without half duplex transmit");
   err_in_frame_a: assert property (o_rx_er |-> o_rx_dv)
      else $error("receive error outside a frame");
   err_on_rise_a: assert property ((!i_rx_dv_pin &&
      $rose(o_rx_er)) |-> $rose(o_rx_clock))
      else $error("receive error off clock rise");
   dv_on_rise_a: assert property ((!i_rx_dv_pin &&
      $changed(o_rx_dv)) |-> $rose(o_rx_clock))
      else $error("data valid off clock rise");
   data_on_rise_a: assert property ((!i_rx_dv_pin &&
      $changed(o_rx_data)) |-> $rose(o_rx_clock))
      else $error("nibble changed off clock rise");
   clk_high_a: assert property ($rose(o_rx_clock) |->
      o_rx_clock[*3]) else $error("receive clock high too short");
   irq_pin_a: assert property ((i_rx_dv_pin && o_rx_dv_oe) |->
      !o_rx_data[2]) else $error("data bit two driven high in rmii");
   mode_out_a: assert property (o_rmii_clock_output_mode |->
      (i_rx_dv_pin && !i_rx_d3_pin)) else $error("clock out mode wrong");
   wake_led_a: assert property ((i_rx_d1_pin && o_rx_dv_oe) |->
      !o_link_led_slow) else $error("led driven while wake chosen");
   oe_order_a: assert property ((o_rx_data_oe != 4'h0) |->
      o_rx_dv_oe) else $error("pin driven before capture");
endmodule
`default_nettype wire

// [tb/prx_mac_model.sv]
// mac receive side: collects nibbles while data valid is high
`timescale 1ns/1ps
`default_nettype none
module prx_mac_model (
   input wire logic i_rx_clock, // receive clock from the phy
   input wire logic [3:0] i_rx_data, // receive nibble
   input wire logic i_rx_dv, // data valid
   input wire logic i_rx_er // receive error
);
   logic [3:0] q[$];
   int n_err = 0;
   // sample on the fall, away from the rise where the phy updates
   always @(negedge i_rx_clock) begin
      if (i_rx_dv === 1'h1) begin
         q.push_back(i_rx_data);
         if (i_rx_er === 1'h1) n_err++;
      end
   end
endmodule
`default_nettype wire

// [tb/prx_top_tb.sv]
// self-checking bench for the receive port, straps, leds and registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module prx_top_tb
   import prx_pkg::*;
;
   logic i_clock = 1'h0, i_rst = 1'h1, i_line_clock = 1'h0, i_line_dv = 1'h0;
   logic i_line_err = 1'h0, i_line_carrier = 1'h0, i_tx_active = 1'h0;
   logic i_full_duplex = 1'h1, i_link_up = 1'h1, i_link_fast = 1'h0;
   logic i_activity = 1'h0, i_wake_event = 1'h0, i_rx_dv_pin = 1'h0;
   logic i_rx_d1_pin = 1'h0, i_rx_d3_pin = 1'h0;
   logic i_led_slow_pin = 1'h0, i_led_fast_pin = 1'h0;
   logic [3:0] i_line_nibble = 4'h0, s_axi_wstrb = 4'hF;
   logic o_rx_clock, o_rx_dv, o_rx_dv_oe, o_rx_er, o_crs, o_col, o_irq;
   logic [3:0] o_rx_data, o_rx_data_oe;
   logic o_link_led_slow, o_link_led_slow_oe, o_link_led_fast;
   logic o_link_led_fast_oe, o_rmii_clock_output_mode;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [3:0] exp_q[$];
   int n_fail = 0, tests_run = 0, cyc = 0, seed = 11810;

   always #10 i_clock = ~i_clock;

   prx_top #(.BLINK_CYCLES(8)) u_prx_top (.*);
   prx_mac_model u_prx_mac_model (.i_rx_clock(o_rx_clock),
      .i_rx_data(o_rx_data), .i_rx_dv(o_rx_dv), .i_rx_er(o_rx_er));

   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // a hang is cut short here and counted as a mismatch
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         finish_test();
      end
   end

   // address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge i_clock);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      rs = s_axi_bresp;
   endtask

   task automatic axi_rd(input logic [7:0] a);
      @(posedge i_clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge i_clock);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask

   // line clock runs for the frame and two nibbles after it, off the system clock's phase
   task automatic send_frame(input int n, input int e);
      logic [3:0] nib;
      #7;
      for (int k = 0; k < n + 2; k++) begin
         nib = 4'($random(seed));
         if (k < n) exp_q.push_back(nib);
         i_line_nibble <= nib;
         i_line_dv <= (k < n);
         i_line_err <= (k == e);
         #80 i_line_clock <= 1'h1;
         #80 i_line_clock <= 1'h0;
      end
   endtask

   function automatic logic [31:0] exp_status(input logic [1:0] m,
      input logic w, input logic [1:0] ad, input logic f);
      return {24'h0, 1'h1, f, 1'h1, ad, w, m};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [1:0] m, ad;
      logic seen;
      int n, e;
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         ad = 2'($random(seed));
         @(posedge i_clock);
         i_rst <= 1'h1;
         i_rx_dv_pin <= m[1];
         i_rx_d3_pin <= m[0];
         i_rx_d1_pin <= 1'($random(seed));
         {i_led_fast_pin, i_led_slow_pin} <= ad;
         i_link_fast <= m[0];
         repeat (2) @(posedge i_clock);
         i_rst <= 1'h0;
         @(posedge i_clock);
         `CHK("enable early", 1'h0, o_rx_dv_oe)
         repeat (6) @(posedge i_clock);
         `CHK("enable late", 1'h1, o_rx_dv_oe)
         `CHK("data oe", m[1] ? 4'hB : 4'hF, o_rx_data_oe)
         `CHK("fast oe", 1'h1, o_link_led_fast_oe)
         `CHK("slow oe", !i_rx_d1_pin, o_link_led_slow_oe)
         i_wake_event <= 1'h1;
         repeat (2) @(posedge i_clock);
         `CHK("wake oe", 1'h1, o_link_led_slow_oe)
         i_wake_event <= 1'h0;
         // the pins now act as outputs, so their levels must not matter
         {i_led_fast_pin, i_led_slow_pin} <= ~ad;
         axi_rd(ADDR_STATUS);
         `CHK("status", exp_status(m, i_rx_d1_pin, ad, m[0]), rd)
         axi_rd(ADDR_CTRL);
         `CHK("ctrl", {30'h0, CTRL_RESET}, rd)
         `CHK("clk mode", m[1] && !m[0], o_rmii_clock_output_mode)
         `CHK("fast led", m[0], o_link_led_fast)
         `CHK("slow led", !(m[0] | i_rx_d1_pin), o_link_led_slow)
         i_activity <= 1'h1;
         @(posedge i_clock);
         i_activity <= 1'h0;
         seen = 1'h0;
         repeat (6) begin
            @(posedge i_clock);
            if ((m[0] ? o_link_led_fast : o_link_led_slow) === 1'h0)
               seen = 1'h1;
         end
         `CHK("blink", 1'h1, seen)
         // odd passes put the error symbol just past the frame
         n = 4 + ($random(seed) & 7);
         e = i[0] ? n : ($random(seed) & 3);
         exp_q.delete();
         u_prx_mac_model.q.delete();
         u_prx_mac_model.n_err = 0;
         i_line_carrier <= 1'h1;
         send_frame(n, e);
         i_full_duplex <= 1'h0;
         i_tx_active <= 1'h1;
         repeat (6) @(posedge i_clock);
         `CHK("carrier", 1'h1, o_crs)
         `CHK("collision", !m[1], o_col)
         i_full_duplex <= 1'h1;
         repeat (2) @(posedge i_clock);
         `CHK("full duplex", 1'h0, o_col)
         i_tx_active <= 1'h0;
         i_line_carrier <= 1'h0;
         if (!m[1]) begin
            `CHK("nibbles", n, u_prx_mac_model.q.size())
            `CHK("errors", int'(e < n), u_prx_mac_model.n_err)
            foreach (exp_q[k])
               `CHK("nibble", exp_q[k], u_prx_mac_model.q[k])
         end
         // frame events are kept in every mode; rmii shows irq on data bit 2
         axi_rd(ADDR_IRQ_STS);
         `CHK("events", {e < n, 1'h1}, rd[1:0])
         `CHK("irq masked", 1'h0, o_irq)
         axi_wr(ADDR_IRQ_MASK, 32'h1);
         repeat (2) @(posedge i_clock);
         `CHK("irq raised", 1'h1, o_irq)
         `CHK("irq pin on", 4'hF, o_rx_data_oe)
         axi_wr(ADDR_IRQ_STS, 32'hF);
         repeat (2) @(posedge i_clock);
         `CHK("irq cleared", 1'h0, o_irq)
         `CHK("irq pin off", m[1] ? 4'hB : 4'hF, o_rx_data_oe)
         axi_wr(ADDR_IRQ_MASK, 32'h0);
      end
      axi_rd(8'h10);
      `CHK("unmapped resp", RESP_SLVERR, rs)
      `CHK("unmapped data", 32'h0, rd)
      axi_wr(8'h14, 32'hFF);
      `CHK("unmapped write", RESP_SLVERR, rs)
      // led enable off darks the lit fast led of the last pass
      axi_wr(ADDR_CTRL, 32'h0);
      repeat (2) @(posedge i_clock);
      `CHK("led off", 1'h0, o_link_led_fast)
      axi_rd(ADDR_CTRL);
      `CHK("ctrl write", 32'h0, rd)
      finish_test();
   end
endmodule
bind prx_top prx_properties u_prx_properties (.*);
`default_nettype wire
